// file: pkg/vdd_pkg.sv
// constants and types shared by both ends of the deflection link
package vdd_pkg;
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned GRID_BITS    = 10;
   localparam int unsigned GRID_POINTS  = 1024;
   localparam int unsigned CODE_BITS    = 8;
   localparam int unsigned PAR_POS      = 8;
   localparam int unsigned BYTES_PER_PT = 4;
   localparam int unsigned SHORT_RU     = 16;
   localparam int unsigned FULL_RU      = 1023;
   localparam int unsigned DIAG_MAX_RU  = 20;
   // settling, travel and fetch times in nanoseconds
   localparam int unsigned SETTLE_NS    = 8000;
   localparam int unsigned TRAVEL_NS    = 92000;
   localparam int unsigned FULL_NS      = 100000;
   localparam int unsigned FETCH_NS     = 4200;
   localparam int unsigned FETCH4_NS    = 16800;
   // hold-off threshold in tenths of a raster unit
   localparam int unsigned HOLD_RU_X10  = 1123;
   localparam int unsigned REFRESH_HZ   = 40;
   localparam int unsigned REFRESH_US   = 25000;
   localparam int unsigned SETTLE_CYC   = SETTLE_NS * CLK_MHZ / 1000;
   localparam int unsigned TRAVEL_CYC   = TRAVEL_NS * CLK_MHZ / 1000;
   localparam int unsigned FETCH_CYC    = (FETCH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned REFRESH_CYC  = REFRESH_US * CLK_MHZ;
   // byte tag on the link: command, order or data
   typedef enum logic [1:0] {
      VDD_KIND_CMD,
      VDD_KIND_ORD,
      VDD_KIND_DATA
   } vdd_kind_t;
   localparam logic [7:0] CMD_WRITE    = 8'h01;
   localparam logic [7:0] ORD_POINT    = 8'h00;
   localparam logic [7:0] ORD_VECTOR   = 8'h01;
   localparam logic [7:0] ORD_CHAR     = 8'h02;
   localparam logic [7:0] ORD_REFRESH  = 8'h03;
   function automatic logic [8:0] vdd_parity(input logic [7:0] code);
      vdd_parity = {~^code, code};
   endfunction
endpackage

// file: pkg/vdd_link_if.sv
// nine-bit byte link between channel end and display end
interface vdd_link_if;
   import vdd_pkg::*;
   logic       valid;
   logic       ready;
   logic [8:0] data;
   vdd_kind_t  kind;
   modport chan (output valid, output data, output kind, input ready);
   modport disp (input valid, input data, input kind, output ready);
endinterface

// file: src/vdd_skid.sv
// two-entry buffer with valid and ready on both sides
module vdd_skid #(
   parameter int unsigned WIDTH = 11
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic             wp_q, wp_d, rp_q, rp_d;
   logic [1:0]       cnt_q, cnt_d;
   logic             push, pop;

   initial begin
      if (WIDTH < 1) $error("vdd_skid: WIDTH must be positive");
   end

   assign in_ready  = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data;
         wp_d = ~wp_q;
      end
      if (pop) begin
         rp_d = ~rp_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'd1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'd1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         cnt_q    <= 2'd0;
      end else begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// file: src/vdd_chan_end.sv
// channel end: frames user commands and points into parity bytes
module vdd_chan_end
   import vdd_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   input  wire logic        PT_VALID,
   output      logic        PT_READY,
   input  wire logic [9:0]  PT_X,
   input  wire logic [9:0]  PT_Y,
   input  wire logic        PT_BEAM_ON,
   input  wire logic        CH_VALID,
   output      logic        CH_READY,
   input  wire logic [7:0]  CH_CODE,
   input  wire logic        MODE_VALID,
   output      logic        MODE_READY,
   input  wire logic [7:0]  MODE_ORDER,
   vdd_link_if.chan         link
);
   typedef enum logic [2:0] {
      CS_IDLE, CS_CMD, CS_ORD, CS_DATA, CS_CHAR
   } vdd_cstate_t;
   vdd_cstate_t state_q, state_d;
   logic [31:0] pt_q, pt_d;
   logic [1:0]  idx_q, idx_d;
   logic [7:0]  ord_q, ord_d;
   logic [7:0]  chr_q, chr_d;
   logic [7:0]  code;
   logic        take;

   assign take       = link.ready;
   assign PT_READY   = (state_q == CS_IDLE) && !MODE_VALID;
   assign MODE_READY = (state_q == CS_IDLE);
   assign CH_READY   = (state_q == CS_IDLE) && !MODE_VALID && !PT_VALID;
   assign link.valid = (state_q != CS_IDLE);

   always_comb begin
      code = 8'h00;
      link.kind = VDD_KIND_DATA;
      case (state_q)
         CS_CMD: begin
            code = CMD_WRITE;
            link.kind = VDD_KIND_CMD;
         end
         CS_ORD: begin
            code = ord_q;
            link.kind = VDD_KIND_ORD;
         end
         CS_DATA: code = pt_q[31 - 8*idx_q -: 8];
         CS_CHAR: code = chr_q;
         default: code = 8'h00;
      endcase
      link.data = vdd_parity(code);
   end

   always_comb begin
      state_d = state_q;
      pt_d    = pt_q;
      idx_d   = idx_q;
      ord_d   = ord_q;
      chr_d   = chr_q;
      case (state_q)
         CS_IDLE: begin
            if (MODE_VALID) begin
               ord_d   = MODE_ORDER;
               state_d = CS_ORD;
            end else if (PT_VALID) begin
               // beam flag rides in spare bit of the X high byte
               pt_d = {5'd0, PT_BEAM_ON, PT_X[9:8], PT_X[7:0],
                       6'd0, PT_Y[9:8], PT_Y[7:0]};
               idx_d   = 2'd0;
               state_d = CS_CMD;
            end else if (CH_VALID) begin
               chr_d   = CH_CODE;
               state_d = CS_CHAR;
            end
         end
         CS_CMD: if (take) state_d = CS_DATA;
         CS_ORD: if (take) state_d = CS_IDLE;
         CS_DATA: begin
            if (take) begin
               idx_d = idx_q + 2'd1;
               if (idx_q == 2'd3) state_d = CS_IDLE;
            end
         end
         CS_CHAR: if (take) state_d = CS_IDLE;
         default: state_d = CS_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= CS_IDLE;
         pt_q    <= '0;
         idx_q   <= 2'd0;
         ord_q   <= ORD_POINT;
         chr_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         pt_q    <= pt_d;
         idx_q   <= idx_d;
         ord_q   <= ord_d;
         chr_q   <= chr_d;
      end
   end
endmodule

// file: src/vdd_disp_end.sv
// display end: byte decode, deflection pacing and refresh control
// Notes on behaviour
// - screen grid 1024 by 1024 points
// - ten-bit coordinate as two bytes each
// - beam moves old to new end point
// - sixteen units or less settle 8 us
// - full screen deflection allowed 100 us
// - hold next move after long deflection (no hold here: the next move starts once the settle count ends)
// - byte fetch 4.2 us, four 16.8
// - redraw whole display every 25 ms
// - buffered refresh local, else program resends
// - nine-bit byte, parity plus eight code
// - one byte selects one character
// - commands pick operation, orders pick mode
// - diagonal vectors limited to 20 units (no limit here: DIAG_ERR flags a longer one and the move is still made)
module vdd_disp_end
   import vdd_pkg::*;
#(
   parameter int unsigned DEPTH       = 256,
   parameter int unsigned REFRESH_CNT = REFRESH_CYC,
   parameter int unsigned FETCH_CNT   = FETCH_CYC,
   parameter bit          HAS_BUFFER  = 1'b1
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   vdd_link_if.disp         link,
   output      logic [9:0]  BEAM_X,
   output      logic [9:0]  BEAM_Y,
   output      logic        BEAM_UNBLANK,
   output      logic        MOVE_STROBE,
   output      logic        CHAR_VALID,
   output      logic [7:0]  CHAR_CODE,
   output      logic        PARITY_ERR,
   output      logic        DIAG_ERR,
   output      logic        FRAME_START,
   output      logic        FRAME_LATE,
   output      logic        BUSY
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned RW = $clog2(REFRESH_CNT + 1);
   localparam int unsigned SW = $clog2(SETTLE_CYC + TRAVEL_CYC + 1);
   initial begin
      if (DEPTH < 2) $error("vdd_disp_end: DEPTH below 2");
      if (REFRESH_CNT < 16) $error("vdd_disp_end: REFRESH_CNT too small");
      if (FETCH_CNT < 1) $error("vdd_disp_end: FETCH_CNT below 1");
   end
   typedef enum logic [2:0] {
      DS_IDLE, DS_COORD, DS_FETCH, DS_MOVE, DS_SETTLE
   } vdd_dstate_t;
   // link bytes pass the two-entry buffer before decode
   logic        bv, br;
   logic [10:0] bd;
   vdd_skid #(.WIDTH(11)) u_skid (
      .clk       (SYS_CLK),
      .rst_n     (RESETN),
      .in_valid  (link.valid),
      .in_ready  (link.ready),
      .in_data   ({link.kind, link.data}),
      .out_valid (bv),
      .out_ready (br),
      .out_data  (bd)
   );
   logic [8:0] byte9;
   logic [1:0] kind;
   assign byte9 = bd[8:0];
   assign kind  = bd[10:9];
   // point store for local refresh
   logic [20:0] mem [DEPTH];
   logic [AW-1:0] wcnt_q, wcnt_d, rptr_q, rptr_d;
   vdd_dstate_t state_q, state_d;
   logic [31:0] acc_q, acc_d;
   logic [1:0]  idx_q, idx_d;
   logic [7:0]  ord_q, ord_d;
   logic [9:0]  x_q, x_d, y_q, y_d;
   logic        ub_q, ub_d;
   logic [SW-1:0] sc_q, sc_d;
   logic [15:0] fc_q, fc_d;
   logic [RW-1:0] rc_q, rc_d;
   logic        replay_q, replay_d, rmv_q, rmv_d;
   logic        mv_q, mv_d, cv_q, cv_d, pe_q, pe_d, de_q, de_d;
   logic        fs_q, fs_d, fl_q, fl_d;
   logic [7:0]  cc_q, cc_d;
   logic        wr_en;
   logic [20:0] wr_data;
   logic [9:0]  nx, ny, dx, dy, dmax;
   logic        beam, par_ok;
   logic [31:0] tcalc;
   assign par_ok = ^byte9;
   // bytes wait in the buffer while a stored point is replayed
   assign br = ((state_q == DS_IDLE) && !replay_q) || (state_q == DS_COORD);
   always_comb begin
      state_d  = state_q;
      acc_d    = acc_q;
      idx_d    = idx_q;
      ord_d    = ord_q;
      x_d      = x_q;
      y_d      = y_q;
      ub_d     = ub_q;
      sc_d     = sc_q;
      fc_d     = fc_q;
      wcnt_d   = wcnt_q;
      rptr_d   = rptr_q;
      replay_d = replay_q;
      rmv_d    = rmv_q;
      mv_d     = 1'b0;
      cv_d     = 1'b0;
      fs_d     = 1'b0;
      fl_d     = fl_q;
      pe_d     = 1'b0;
      de_d     = 1'b0;
      cc_d     = cc_q;
      wr_en    = 1'b0;
      wr_data  = '0;
      // a replayed move takes its end point from the store
      nx   = rmv_q ? mem[rptr_q][19:10] : acc_q[25:16];
      ny   = rmv_q ? mem[rptr_q][9:0] : acc_q[9:0];
      beam = rmv_q ? mem[rptr_q][20] : acc_q[26];
      dx = (nx > x_q) ? nx - x_q : x_q - nx;
      dy = (ny > y_q) ? ny - y_q : y_q - ny;
      dmax = (dx > dy) ? dx : dy;
      // settle plus scaled travel beyond 16 units
      tcalc = 32'(SETTLE_CYC);
      if (dmax > 10'(SHORT_RU)) begin
         tcalc = 32'(SETTLE_CYC) + 32'(TRAVEL_CYC) * 32'(dmax - 10'(SHORT_RU))
                 / 32'(FULL_RU - SHORT_RU);
      end
      rc_d = (rc_q == RW'(REFRESH_CNT - 1)) ? '0 : rc_q + RW'(1);
      if (rc_q == RW'(REFRESH_CNT - 1)) begin
         fs_d = 1'b1;
         fl_d = replay_q;
         if (HAS_BUFFER && wcnt_q != '0 && !replay_q) begin
            replay_d = 1'b1;
            rptr_d   = '0;
         end
      end
      case (state_q)
         DS_IDLE: begin
            rmv_d = replay_q;
            if (replay_q) begin
               state_d = DS_FETCH;
               fc_d    = 16'(BYTES_PER_PT * FETCH_CNT);
            end else if (bv) begin
               if (!par_ok) begin
                  pe_d = 1'b1;
               // command starts operation, order sets mode
               end else if (kind == 2'(VDD_KIND_CMD)) begin
                  if (byte9[7:0] == CMD_WRITE) begin
                     idx_d   = 2'd0;
                     state_d = DS_COORD;
                  end
               end else if (kind == 2'(VDD_KIND_ORD)) begin
                  ord_d = byte9[7:0];
                  if (byte9[7:0] == ORD_REFRESH) wcnt_d = '0;
               end else if (ord_q == ORD_CHAR) begin
                  cc_d = byte9[7:0];
                  cv_d = 1'b1;
               end
            end
         end
         DS_COORD: begin
            if (bv) begin
               if (!par_ok) pe_d = 1'b1;
               // collect four bytes, X then Y, high first
               acc_d = {acc_q[23:0], byte9[7:0]};
               idx_d = idx_q + 2'd1;
               if (idx_q == 2'd3) state_d = DS_MOVE;
            end
         end
         DS_FETCH: begin
            fc_d = fc_q - 16'd1;
            if (fc_q == 16'd1) state_d = DS_MOVE;
         end
         DS_MOVE: begin
            // move from old end point to the new one
            x_d  = nx;
            y_d  = ny;
            mv_d = 1'b1;
            ub_d = beam && (ord_q == ORD_VECTOR);
            if (beam && dx != 0 && dy != 0 && (dx != dy || dx > 10'(DIAG_MAX_RU)))
               de_d = 1'b1;
            if (!rmv_q && HAS_BUFFER && wcnt_q != AW'(DEPTH - 1)) begin
               wr_en   = 1'b1;
               wr_data = {beam, nx, ny};
               wcnt_d  = wcnt_q + AW'(1);
            end
            // settle counter from larger axis distance
            sc_d    = SW'(tcalc);
            state_d = DS_SETTLE;
         end
         DS_SETTLE: begin
            sc_d = sc_q - SW'(1);
            if (sc_q <= SW'(1)) begin
               ub_d = (ord_q == ORD_POINT) ? beam : ub_q;
               state_d = DS_IDLE;
               if (rmv_q) begin
                  rptr_d = rptr_q + AW'(1);
                  if (rptr_q + AW'(1) == wcnt_q) replay_d = 1'b0;
               end
            end
         end
         default: state_d = DS_IDLE;
      endcase
   end
   always_ff @(posedge SYS_CLK) begin
      if (wr_en) mem[wcnt_q] <= wr_data;
   end
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q  <= DS_IDLE;
         acc_q    <= '0;
         idx_q    <= 2'd0;
         ord_q    <= ORD_POINT;
         x_q      <= '0;
         y_q      <= '0;
         ub_q     <= 1'b0;
         sc_q     <= '0;
         fc_q     <= '0;
         rc_q     <= '0;
         wcnt_q   <= '0;
         rptr_q   <= '0;
         replay_q <= 1'b0;
         rmv_q    <= 1'b0;
         mv_q     <= 1'b0;
         cv_q     <= 1'b0;
         pe_q     <= 1'b0;
         de_q     <= 1'b0;
         fs_q     <= 1'b0;
         fl_q     <= 1'b0;
         cc_q     <= 8'h00;
      end else begin
         state_q  <= state_d;
         acc_q    <= acc_d;
         idx_q    <= idx_d;
         ord_q    <= ord_d;
         x_q      <= x_d;
         y_q      <= y_d;
         ub_q     <= ub_d;
         sc_q     <= sc_d;
         fc_q     <= fc_d;
         rc_q     <= rc_d;
         wcnt_q   <= wcnt_d;
         rptr_q   <= rptr_d;
         replay_q <= replay_d;
         rmv_q    <= rmv_d;
         mv_q     <= mv_d;
         cv_q     <= cv_d;
         pe_q     <= pe_d;
         de_q     <= de_d;
         fs_q     <= fs_d;
         fl_q     <= fl_d;
         cc_q     <= cc_d;
      end
   end
   assign BEAM_X       = x_q;
   assign BEAM_Y       = y_q;
   assign BEAM_UNBLANK = ub_q;
   assign MOVE_STROBE  = mv_q;
   assign CHAR_VALID   = cv_q;
   assign CHAR_CODE    = cc_q;
   assign PARITY_ERR   = pe_q;
   assign DIAG_ERR     = de_q;
   assign FRAME_START  = fs_q;
   assign FRAME_LATE   = fl_q;
   assign BUSY         = (state_q != DS_IDLE);
endmodule

// file: tb/vdd_link_sva.sv
// protocol checker for the byte link between the two ends
module vdd_link_sva
   import vdd_pkg::*;
(
   input wire logic       SYS_CLK,
   input wire logic       RESETN,
   input wire logic       valid,
   input wire logic       ready,
   input wire logic [8:0] data,
   input wire vdd_kind_t  kind
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] idx_q;
   logic [2:0] idx_d;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   // position of the next byte inside a point frame
   always_comb begin
      idx_d = idx_q;
      if (valid && ready) begin
         if (kind == VDD_KIND_CMD) begin
            idx_d = 3'h1;
         end else if (idx_q != 3'h0) begin
            idx_d = (idx_q == 3'h4) ? 3'h0 : idx_q + 3'h1;
         end
      end
   end
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         idx_q <= 3'h0;
      end else begin
         idx_q <= idx_d;
      end
   end
   a_valid_held: assert property (valid && !ready |=> valid)
      else $error("valid dropped before transfer");
   a_byte_held: assert property (
      valid && !ready |=> $stable(data) && $stable(kind))
      else $error("byte changed while waiting");
   a_odd_parity: assert property (valid |-> ^data)
      else $error("parity not odd");
   a_cmd_write: assert property (
      valid && kind == VDD_KIND_CMD |-> data[7:0] == CMD_WRITE)
      else $error("unknown command code");
   a_order_known: assert property (
      valid && kind == VDD_KIND_ORD |-> data[7:0] <= ORD_REFRESH)
      else $error("unknown order code");
   a_point_data: assert property (
      valid && idx_q != 3'h0 |-> kind == VDD_KIND_DATA)
      else $error("point frame broken");
   a_x_hi_field: assert property (
      valid && idx_q == 3'h1 |-> data[7:3] == 5'h0_0)
      else $error("x high byte too wide");
   a_y_hi_field: assert property (
      valid && idx_q == 3'h3 |-> data[7:2] == 6'h00)
      else $error("y high byte too wide");
endmodule

// file: tb/vdd_bench.sv
// testbench: channel end and display end joined by the byte link
module vdd_bench
   import vdd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RCNT = 5000;
   localparam int FCNT = 2;
   logic       SYS_CLK, RESETN, PT_VALID, PT_BEAM_ON, CH_VALID, MODE_VALID;
   logic [9:0] PT_X, PT_Y, BEAM_X, BEAM_Y, bx2;
   logic [7:0] CH_CODE, MODE_ORDER, CHAR_CODE, chr_last;
   logic       PT_READY, CH_READY, MODE_READY, BEAM_UNBLANK, MOVE_STROBE;
   logic       CHAR_VALID, DIAG_ERR, BUSY, mv2, fs2, perr2, fl2, vec;
   int         failures = 0, n_tests = 0, cyc = 0, mv_n = 0, diag_n = 0;
   int         chr_n = 0, mv2_n = 0, fs2_n = 0, fs2_at = 0, fs2_gap = 0;
   int         mv2_at = 0, perr_n = 0;
   vdd_link_if link_a ();
   vdd_link_if link_b ();
   vdd_chan_end u_vdd_chan_end (.SYS_CLK, .RESETN, .PT_VALID, .PT_READY,
      .PT_X, .PT_Y, .PT_BEAM_ON, .CH_VALID, .CH_READY, .CH_CODE,
      .MODE_VALID, .MODE_READY, .MODE_ORDER, .link(link_a));
   vdd_disp_end #(.DEPTH(4), .REFRESH_CNT(RCNT), .FETCH_CNT(FCNT),
      .HAS_BUFFER(1'b0)) u_vdd_disp_end (.SYS_CLK, .RESETN,
      .link(link_a), .BEAM_X, .BEAM_Y, .BEAM_UNBLANK, .MOVE_STROBE,
      .CHAR_VALID, .CHAR_CODE, .PARITY_ERR(), .DIAG_ERR,
      .FRAME_START(), .FRAME_LATE(), .BUSY);
   vdd_disp_end #(.DEPTH(4), .REFRESH_CNT(RCNT), .FETCH_CNT(FCNT),
      .HAS_BUFFER(1'b1)) u_vdd_disp_end_b (.SYS_CLK, .RESETN,
      .link(link_b), .BEAM_X(bx2), .BEAM_Y(), .BEAM_UNBLANK(),
      .MOVE_STROBE(mv2), .CHAR_VALID(), .CHAR_CODE(), .PARITY_ERR(perr2),
      .DIAG_ERR(), .FRAME_START(fs2), .FRAME_LATE(fl2), .BUSY());
   vdd_link_sva u_vdd_link_sva (.SYS_CLK, .RESETN, .valid(link_a.valid),
      .ready(link_a.ready), .data(link_a.data), .kind(link_a.kind));

   initial begin
      SYS_CLK = 1'b0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   // event counters sampled where outputs are settled
   always @(negedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (MOVE_STROBE === 1'b1) mv_n <= mv_n + 1;
      if (DIAG_ERR === 1'b1) diag_n <= diag_n + 1;
      if (perr2 === 1'b1) perr_n <= perr_n + 1;
      if (CHAR_VALID === 1'b1) begin
         chr_n <= chr_n + 1;
         chr_last <= CHAR_CODE;
      end
      if (mv2 === 1'b1) begin
         mv2_n <= mv2_n + 1;
         mv2_at <= cyc;
      end
      if (fs2 === 1'b1) begin
         fs2_n <= fs2_n + 1;
         fs2_gap <= cyc - fs2_at;
         fs2_at <= cyc;
      end
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic results();
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_cnt(ref int c, input int target, input int lim);
      int n;
      n = 0;
      while (c < target && n < lim) begin
         @(negedge SYS_CLK);
         n++;
      end
      check("wait bound", 1, n < lim);
   endtask
   // raise one request, hold it until the edge that takes it
   task automatic req(input int sel);
      int n;
      @(posedge SYS_CLK);
      PT_VALID <= (sel == 0);
      CH_VALID <= (sel == 1);
      MODE_VALID <= (sel == 2);
      n = 0;
      do begin
         @(negedge SYS_CLK);
         n++;
      end while (((sel == 0) ? PT_READY : (sel == 1) ? CH_READY
                 : MODE_READY) !== 1'b1 && n < 40000);
      @(posedge SYS_CLK);
      PT_VALID <= 1'b0;
      CH_VALID <= 1'b0;
      MODE_VALID <= 1'b0;
      check("request taken", 1, n < 40000);
   endtask
   task automatic move(input logic [9:0] x, input logic [9:0] y,
                       input logic on, input int d, input logic de);
      int m, b, e, n;
      m = mv_n;
      b = diag_n;
      @(posedge SYS_CLK);
      PT_X <= x;
      PT_Y <= y;
      PT_BEAM_ON <= on;
      req(0);
      wait_cnt(mv_n, m + 1, 3000);
      check("beam x", x, BEAM_X);
      check("beam y", y, BEAM_Y);
      // vector mode draws during the move, point mode only after it
      check("beam in move", on & vec, BEAM_UNBLANK);
      e = SETTLE_CYC;
      if (d > SHORT_RU) e += TRAVEL_CYC * (d - SHORT_RU) / (FULL_RU - SHORT_RU);
      n = 0;
      while (BUSY !== 1'b0 && n < 30000) begin
         @(negedge SYS_CLK);
         n++;
      end
      check("settle cycles", e, (n + 6 >= e && n <= e + 6) ? e : n);
      check("beam after move", on, BEAM_UNBLANK);
      check("diagonal flag", de, diag_n != b);
   endtask
   function automatic logic [8:0] par(input logic [7:0] c);
      return {~^c, c};
   endfunction
   task automatic send_b(input vdd_kind_t k, input logic [8:0] d);
      int n;
      @(posedge SYS_CLK);
      link_b.valid <= 1'b1;
      link_b.kind <= k;
      link_b.data <= d;
      n = 0;
      do begin
         @(negedge SYS_CLK);
         n++;
      end while (link_b.ready !== 1'b1 && n < 100);
      @(posedge SYS_CLK);
      link_b.valid <= 1'b0;
      link_b.data <= ~d;
   endtask

   initial begin
      int f, p;
      {RESETN, PT_VALID, PT_BEAM_ON, CH_VALID, MODE_VALID, vec} = 6'h00;
      {PT_X, PT_Y, CH_CODE, MODE_ORDER} = 36'h0_0000_0000;
      link_b.valid = 1'b0;
      link_b.data = 9'h000;
      link_b.kind = VDD_KIND_CMD;
      repeat (15) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      check("reset beam", 0, {BEAM_X, BEAM_Y, BEAM_UNBLANK, BUSY});
      check("reset link", 2'h1, {link_a.valid, link_a.ready});
      @(posedge SYS_CLK);
      RESETN <= 1'b1;
      move(10'h005, 10'h009, 1'b0, 9, 1'b0);
      move(10'h015, 10'h009, 1'b1, 16, 1'b0);
      move(10'h001, 10'h01d, 1'b1, 20, 1'b0);
      move(10'h016, 10'h032, 1'b1, 21, 1'b1);
      move(10'h087, 10'h032, 1'b0, 113, 1'b0);
      move(10'h000, 10'h032, 1'b0, 135, 1'b0);
      move(10'h3ff, 10'h032, 1'b1, 1023, 1'b0);
      move(10'h3ff, 10'h000, 1'b1, 50, 1'b0);
      for (int o = 0; o < 4; o++) begin
         @(posedge SYS_CLK);
         MODE_ORDER <= o[7:0];
         req(2);
      end
      // vector mode keeps the beam on while it travels
      MODE_ORDER <= ORD_VECTOR;
      req(2);
      vec = 1'b1;
      move(10'h3ff, 10'h100, 1'b1, 256, 1'b0);
      @(posedge SYS_CLK);
      MODE_ORDER <= ORD_CHAR;
      req(2);
      f = chr_n;
      @(posedge SYS_CLK);
      CH_CODE <= 8'h41;
      req(1);
      CH_CODE <= 8'h5a;
      req(1);
      wait_cnt(chr_n, f + 2, 200);
      check("char code", 8'h5a, chr_last);
      send_b(VDD_KIND_CMD, par(CMD_WRITE));
      send_b(VDD_KIND_DATA, par(8'h04));
      send_b(VDD_KIND_DATA, par(8'h03));
      send_b(VDD_KIND_DATA, par(8'h00));
      send_b(VDD_KIND_DATA, par(8'h04));
      wait_cnt(mv2_n, 1, 500);
      check("stored x", 10'h003, bx2);
      // let the live settle and any replay it delayed run out
      repeat (4200) @(negedge SYS_CLK);
      f = fs2_n;
      wait_cnt(fs2_n, f + 1, 2 * RCNT + 10);
      p = mv2_n;
      wait_cnt(mv2_n, p + 1, 300);
      p = mv2_at - fs2_at;
      check("replay delay", 1, p >= 4 * FCNT && p <= 4 * FCNT + 40);
      wait_cnt(fs2_n, f + 2, RCNT + 10);
      check("frame period", RCNT, fs2_gap);
      check("frame late", 0, fl2);
      p = perr_n;
      send_b(VDD_KIND_DATA, par(8'h41) ^ 9'h100);
      // the byte waits in the buffer until this frame's replay ends
      wait_cnt(perr_n, p + 1, RCNT);
      results();
   end
   initial begin
      #(90000 * 4);
      failures++;
      $display("wrong value watchdog expected done seen hang");
      results();
   end
endmodule
